/* File: nlf_core.v */
// Lock gating, fuse latching, signature and calibration readout
// What this block does
// - Boot mode 1 leaves store and load free
// - Boot mode 2 blocks stores into boot
// - Mode 3 blocks boot stores and app loads
// - Mode 4 allows stores, blocks app loads
// - Modes 3,4 mask interrupts in boot code
// - Programmed fuse reads 0, unprogrammed 1
// - Serial-prog fuse untouchable in serial mode
// - Keep-eeprom fuse preserves EEPROM on erase
// - Debug fuse keeps clocks running in sleep
// - Clock select defaults 0001, RC 1MHz
// - Start-up fuses default 10, longest delay
// - Chip erase leaves fuses unchanged
// - Memory lock first freezes fuse writes
// - Fuses latched on programming entry and exit
// - Keep-eeprom fuse acts immediately
// - Fuses latched at power-up normal mode
// - Three signature bytes, readable when locked
// - Four calibration bytes for 1,2,4,8 MHz
// - 1MHz calibration loaded during reset
// - Flash 128 pages of 64 words
// - Lock bits return to 1 only by erase or reset
`include "nlf_defines.vh"
module nlf_core #(
   parameter [7:0] SIG_BYTE0 = 8'hA5,          // Arbitrary identity value
   parameter [7:0] SIG_BYTE1 = 8'h5A,          // Arbitrary identity value
   parameter [7:0] SIG_BYTE2 = 8'h3C,          // Arbitrary identity value
   parameter [7:0] CAL_1MHZ  = 8'h80,          // Calibration trim, 1 MHz
   parameter [7:0] CAL_2MHZ  = 8'h80,          // Calibration trim, 2 MHz
   parameter [7:0] CAL_4MHZ  = 8'h80,          // Calibration trim, 4 MHz
   parameter [7:0] CAL_8MHZ  = 8'h80           // Calibration trim, 8 MHz
) (
   input  wire        i_mclk,                  // System clock
   input  wire        i_rstn,                  // Sync reset, active low
   input  wire        i_prog_mode,             // Programming mode (pin domain)
   input  wire        i_serial_mode,           // Serial programming mode (pin domain)
   input  wire        i_fuse_wr,               // Fuse write strobe
   input  wire        i_fuse_sel_high,         // 1 selects high fuse byte
   input  wire [7:0]  i_fuse_wdata,            // Fuse write data
   input  wire        i_lock_wr,               // Lock write strobe
   input  wire [7:0]  i_lock_wdata,            // Lock write data
   input  wire        i_chip_erase,            // Chip erase strobe
   input  wire        i_sig_rd,                // Signature row read strobe
   input  wire        i_sig_sel_cal,           // 1 reads calibration byte
   input  wire [1:0]  i_sig_addr,              // Signature row address
   input  wire        i_trim_wr,               // Software trim load strobe
   input  wire [7:0]  i_trim_wdata,            // Software trim value
   input  wire        i_pm_store,              // Program-memory store request
   input  wire        i_pm_load,               // Program-memory load request
   input  wire [12:0] i_exec_pc,               // Address of executing instruction
   input  wire [12:0] i_target_addr,           // Target word address
   input  wire        i_vectors_in_boot,       // Interrupt vectors in boot section
   input  wire [8:0]  i_ee_addr,               // EEPROM byte address
   output reg  [7:0]  o_config_fuse_high_byte, // Stored high fuse byte
   output reg  [7:0]  o_config_fuse_low_byte,  // Stored low fuse byte
   output reg  [7:0]  o_lock_byte,             // Stored lock byte
   output reg  [7:0]  o_active_fuse_high,      // Latched high fuses in effect
   output reg  [7:0]  o_active_fuse_low,       // Latched low fuses in effect
   output reg         o_keep_eeprom,           // EEPROM kept through erase
   output reg         o_eeprom_erase,          // One-cycle EEPROM erase pulse
   output reg         o_flash_erase,           // One-cycle flash erase pulse
   output reg         o_clocks_in_sleep,       // Keep clocks running in sleep
   output reg  [7:0]  o_sig_rdata,             // Signature row read data
   output reg  [7:0]  o_oscillator_trim_register, // Oscillator trim value
   output reg         o_store_allow,           // Store permitted
   output reg         o_load_allow,            // Load permitted
   output reg         o_irq_block,             // Interrupts suppressed
   output reg  [6:0]  o_flash_page_select,     // Flash page of target
   output reg  [5:0]  o_flash_word_in_page,    // Word within flash page
   output reg  [6:0]  o_eeprom_page,           // EEPROM page
   output reg  [1:0]  o_eeprom_byte_in_page    // Byte within EEPROM page
);

// ==========================================================
// Pin synchronisers
reg [1:0] prog_sync_r;                         // Programming mode sync chain
reg [1:0] ser_sync_r;                          // Serial mode sync chain
wire      prog_mode = prog_sync_r[1];          // Synchronised programming mode
wire      ser_mode  = ser_sync_r[1];           // Synchronised serial mode

// Two stages, only the second is read by logic. The mode pins come from
// the programmer with no relation to this clock, so every decision below
// sees them two cycles late; the programmer must allow for that.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      prog_sync_r <= 2'h0;
      ser_sync_r  <= 2'h0;
   end else begin
      prog_sync_r <= {prog_sync_r[0], i_prog_mode};
      ser_sync_r  <= {ser_sync_r[0], i_serial_mode};
   end
end

// ==========================================================
// Stored fuse and lock bytes
// A fuse write needs programming mode and an unprogrammed first memory
// lock; anything else is dropped silently, as the pins give no status.
reg       prog_mode_d_r;                       // Previous programming mode
reg       boot_done_r;                         // Power-up latch already taken
wire      prog_enter = prog_mode & ~prog_mode_d_r;
wire      prog_leave = ~prog_mode & prog_mode_d_r;
wire      fuse_ok    = i_fuse_wr & prog_mode & o_lock_byte[`NLF_LK_MEM_FIRST];
reg [7:0] fh_nxt;                              // Next stored high fuse byte

// Serial-prog fuse keeps its value when written over serial,
// so a serial programmer can never lock itself out of the part
always @* begin
   fh_nxt = i_fuse_wdata;
   if (ser_mode) begin
      fh_nxt[`NLF_FH_SERIAL_PROG] = o_config_fuse_high_byte[`NLF_FH_SERIAL_PROG];
   end
end

// Fuses hold reset value as shipping default; stored bits are active low
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_config_fuse_high_byte <= `NLF_FUSE_HIGH_RST;
      o_config_fuse_low_byte  <= `NLF_FUSE_LOW_RST;
      o_lock_byte             <= `NLF_LOCK_ERASED;
   end else begin
      // Chip erase never touches fuses
      if (fuse_ok && i_fuse_sel_high) begin
         o_config_fuse_high_byte <= fh_nxt;
      end
      if (fuse_ok && !i_fuse_sel_high) begin
         o_config_fuse_low_byte <= i_fuse_wdata;
      end
      // Erase restores ones; writes can only clear bits
      // Erase is tested first so that it wins over a lock write in the
      // same cycle; a lock write cannot undo a pending erase.
      if (i_chip_erase && prog_mode) begin
         o_lock_byte <= `NLF_LOCK_ERASED;
      end else if (i_lock_wr && prog_mode) begin
         o_lock_byte <= o_lock_byte & i_lock_wdata;
      end
   end
end

// ==========================================================
// Fuse latching into the active copies
// Latched after release of reset in normal mode, and on programming entry;
// writes in programming mode wait until leaving it.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      prog_mode_d_r      <= 1'b0;
      boot_done_r        <= 1'b0;
      o_active_fuse_high <= `NLF_FUSE_HIGH_RST;
      o_active_fuse_low  <= `NLF_FUSE_LOW_RST;
   end else begin
      prog_mode_d_r <= prog_mode;
      // Latch on leaving as well, so writes made in programming mode
      // take effect as soon as the part runs again.
      if ((!boot_done_r && !prog_mode) || prog_enter || prog_leave) begin
         boot_done_r        <= 1'b1;
         o_active_fuse_high <= o_config_fuse_high_byte;
         o_active_fuse_low  <= o_config_fuse_low_byte;
      end else if (prog_mode) begin
         // Programming came first: no power-up latch is due any more
         boot_done_r <= 1'b1;
      end
   end
end

// ==========================================================
// Erase outputs and fuse effects
// Keep-eeprom follows the stored fuse directly, not the latched copy
// Erase pulses last one cycle; the memory controllers act on them.
// Stored bit high means unprogrammed, so then the EEPROM is wiped too.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_keep_eeprom     <= 1'b0;
      o_eeprom_erase    <= 1'b0;
      o_flash_erase     <= 1'b0;
      o_clocks_in_sleep <= 1'b0;
   end else begin
      o_keep_eeprom     <= ~o_config_fuse_high_byte[`NLF_FH_KEEP_EE];
      o_flash_erase     <= i_chip_erase & prog_mode;
      o_eeprom_erase    <= i_chip_erase & prog_mode &
                           o_config_fuse_high_byte[`NLF_FH_KEEP_EE];
      o_clocks_in_sleep <= ~o_active_fuse_high[`NLF_FH_DEBUG_EN];
   end
end

// ==========================================================
// Signature and calibration readout, no lock check applied
// The identity bytes stay readable on a locked part on purpose.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_sig_rdata <= 8'h00;
   end else if (i_sig_rd) begin
      if (i_sig_sel_cal) begin
         case (i_sig_addr)
            `NLF_SIG_ADDR_0: o_sig_rdata <= CAL_1MHZ;
            `NLF_SIG_ADDR_1: o_sig_rdata <= CAL_2MHZ;
            `NLF_SIG_ADDR_2: o_sig_rdata <= CAL_4MHZ;
            default:         o_sig_rdata <= CAL_8MHZ;
         endcase
      end else begin
         case (i_sig_addr)
            `NLF_SIG_ADDR_0: o_sig_rdata <= SIG_BYTE0;
            `NLF_SIG_ADDR_1: o_sig_rdata <= SIG_BYTE1;
            `NLF_SIG_ADDR_2: o_sig_rdata <= SIG_BYTE2;
            default:         o_sig_rdata <= 8'h00;
         endcase
      end
   end
end

// Trim register: 1 MHz value loaded in reset, software may override
// Reset wins over a software load in the same cycle.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_oscillator_trim_register <= CAL_1MHZ;
   end else if (i_trim_wr) begin
      o_oscillator_trim_register <= i_trim_wdata;
   end
end

// ==========================================================
// Boot lock decision
// Section test uses the latched boot size, so a new size counts only
// after latching; addresses at or above the boot start are boot.
reg  [12:0] boot_start;                        // Boot section first word
wire [1:0]  boot_sz = o_active_fuse_high[`NLF_FH_BOOT_SZ_HI:`NLF_FH_BOOT_SZ_LO];
wire [1:0]  blb = {o_lock_byte[`NLF_LK_BOOT_UPPER], o_lock_byte[`NLF_LK_BOOT_LOWER]};
wire        tgt_boot  = (i_target_addr >= boot_start);
wire        exec_boot = (i_exec_pc >= boot_start);
reg         st_ok_nxt;                         // Store allowed next
reg         ld_ok_nxt;                         // Load allowed next
reg         irq_nxt;                           // Interrupt block next

// Boot start from boot-size fuses
// Larger boot sections start lower; code 11 gives the smallest one
always @* begin
   case (boot_sz)
      2'h3:    boot_start = `NLF_BOOT_START_11;
      2'h2:    boot_start = `NLF_BOOT_START_10;
      2'h1:    boot_start = `NLF_BOOT_START_01;
      default: boot_start = `NLF_BOOT_START_00;
   endcase
end

// Mode table on the boot lock pair
always @* begin
   st_ok_nxt = 1'b1;
   ld_ok_nxt = 1'b1;
   irq_nxt   = 1'b0;
   // Pair 11 is mode 1, 10 mode 2, 00 mode 3, 01 mode 4
   case (blb)
      2'h3: begin
         st_ok_nxt = 1'b1;
      end
      2'h2: begin
         st_ok_nxt = ~tgt_boot;
      end
      2'h0: begin
         st_ok_nxt = ~tgt_boot;
         ld_ok_nxt = ~(tgt_boot & ~exec_boot);
         irq_nxt   = exec_boot & ~i_vectors_in_boot;
      end
      default: begin
         ld_ok_nxt = ~(tgt_boot & ~exec_boot);
         irq_nxt   = exec_boot & ~i_vectors_in_boot;
      end
   endcase
end

// Registered verdicts, one cycle after the request
// Permission shows only while a request stands; no request gives 0.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_store_allow <= 1'b0;
      o_load_allow  <= 1'b0;
      o_irq_block   <= 1'b0;
   end else begin
      o_store_allow <= i_pm_store & st_ok_nxt;
      o_load_allow  <= i_pm_load & ld_ok_nxt;
      o_irq_block   <= irq_nxt;
   end
end

// ==========================================================
// Page geometry split
// Split is purely positional; page sizes are fixed at 64 words and
// 4 bytes, so no arithmetic is needed on the addresses.
always @(posedge i_mclk) begin
   if (!i_rstn) begin
      o_flash_page_select   <= 7'h00;
      o_flash_word_in_page  <= 6'h00;
      o_eeprom_page         <= 7'h00;
      o_eeprom_byte_in_page <= 2'h0;
   end else begin
      o_flash_page_select   <= i_target_addr[`NLF_PC_TOP:`NLF_PC_PAGE_LO];
      o_flash_word_in_page  <= i_target_addr[`NLF_PC_WORD_HI:0];
      o_eeprom_page         <= i_ee_addr[`NLF_EE_TOP:`NLF_EE_PAGE_LO];
      o_eeprom_byte_in_page <= i_ee_addr[`NLF_EE_BYTE_HI:0];
   end
end

endmodule // nlf_core

/* File: nlf_defines.vh */
// Constants for the non-volatile lock, fuse and calibration block
`ifndef NLF_DEFINES_VH
`define NLF_DEFINES_VH
// ==========================================================
// Fuse high byte fields
`define NLF_FH_DEBUG_EN      7
`define NLF_FH_SCAN_EN       6
`define NLF_FH_SERIAL_PROG   5
`define NLF_FH_OSC_OPT       4
`define NLF_FH_KEEP_EE       3
`define NLF_FH_BOOT_SZ_HI    2
`define NLF_FH_BOOT_SZ_LO    1
`define NLF_FH_RST_VEC       0
`define NLF_FUSE_HIGH_RST    8'h99
// ==========================================================
// Fuse low byte fields
`define NLF_FL_BROWN_LVL     7
`define NLF_FL_BROWN_EN      6
`define NLF_FL_SUT_HI        5
`define NLF_FL_SUT_LO        4
`define NLF_FL_CKSEL_HI      3
`define NLF_FL_CKSEL_LO      0
`define NLF_FUSE_LOW_RST     8'hE1
// ==========================================================
// Lock byte fields and erased value
`define NLF_LK_BOOT_UPPER    5
`define NLF_LK_BOOT_LOWER    4
`define NLF_LK_MEM_FIRST     0
`define NLF_LOCK_ERASED      8'hFF
// ==========================================================
// Boot section start per boot-size code (word addresses)
`define NLF_BOOT_START_11    13'h1F80
`define NLF_BOOT_START_10    13'h1F00
`define NLF_BOOT_START_01    13'h1E00
`define NLF_BOOT_START_00    13'h1C00
// ==========================================================
// Signature space addresses
`define NLF_SIG_ADDR_0       2'h0
`define NLF_SIG_ADDR_1       2'h1
`define NLF_SIG_ADDR_2       2'h2
// ==========================================================
// Flash and EEPROM geometry
`define NLF_PC_TOP           12
`define NLF_PC_WORD_HI       5
`define NLF_PC_PAGE_LO       6
`define NLF_EE_TOP           8
`define NLF_EE_BYTE_HI       1
`define NLF_EE_PAGE_LO       2
`endif

/* File: nlf_core_checker.sv */
// Checker for nlf_core: lock gating, fuse freezing, latching and geometry
module nlf_core_checker #(
   parameter logic [7:0] CAL_1MHZ = 8'h80 // Trim loaded while in reset
) (
   input wire        i_mclk,
   input wire        i_rstn,
   input wire        i_prog_mode,
   input wire        i_pm_store,
   input wire        i_pm_load,
   input wire [12:0] i_exec_pc,
   input wire [12:0] i_target_addr,
   input wire        i_vectors_in_boot,
   input wire [7:0]  o_config_fuse_high_byte,
   input wire [7:0]  o_config_fuse_low_byte,
   input wire [7:0]  o_lock_byte,
   input wire [7:0]  o_active_fuse_high,
   input wire [7:0]  o_oscillator_trim_register,
   input wire        o_clocks_in_sleep,
   input wire        o_store_allow,
   input wire        o_load_allow,
   input wire        o_irq_block,
   input wire [6:0]  o_flash_page_select,
   input wire [5:0]  o_flash_word_in_page
);
   // ====================================
   // Common clock and reset
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // ====================================
   // Addresses at or above 1F80 are boot for every boot size, below 1C00 never
   a_store_boot_gate: assert property (i_pm_store && i_exec_pc < 13'h1C00 &&
      i_target_addr >= 13'h1F80 |=> o_store_allow == $past(o_lock_byte[4]))
      else $error("store into boot section gated wrongly");
   a_load_boot_gate: assert property (i_pm_load && i_exec_pc < 13'h1C00 &&
      i_target_addr >= 13'h1F80 |=> o_load_allow == $past(o_lock_byte[5]))
      else $error("load of boot section from application gated wrongly");
   a_irq_boot_mask: assert property (i_exec_pc >= 13'h1F80 && !i_vectors_in_boot
      |=> o_irq_block != $past(o_lock_byte[5]))
      else $error("interrupt suppression in boot code wrong");
   a_flash_page_map: assert property ($past(i_rstn) |->
      {o_flash_page_select, o_flash_word_in_page} == $past(i_target_addr))
      else $error("flash page or word split wrong");
   a_fuse_write_frozen: assert property (!o_lock_byte[0] |=>
      $stable(o_config_fuse_high_byte) && $stable(o_config_fuse_low_byte))
      else $error("fuse changed with first memory lock programmed");
   a_trim_reset_load: assert property (disable iff (1'b0) !i_rstn |=>
      o_oscillator_trim_register == CAL_1MHZ)
      else $error("trim not loaded from 1 MHz value in reset");
   a_active_hold_prog: assert property (i_prog_mode [*4] |=>
      $stable(o_active_fuse_high))
      else $error("active fuses changed inside programming mode");
   a_sleep_clock_fuse: assert property ($stable(o_active_fuse_high) |->
      o_clocks_in_sleep != o_active_fuse_high[7])
      else $error("sleep clock keep does not follow debug fuse");
   // ====================================
   // Main scenarios reached
   c_store_refused: cover property (i_pm_store ##1 !o_store_allow);
   c_load_refused: cover property (i_pm_load ##1 !o_load_allow);
   c_irq_masked: cover property (o_irq_block);
endmodule // nlf_core_checker

bind nlf_core nlf_core_checker #(.CAL_1MHZ(CAL_1MHZ)) u_chk (.*);

/* File: nlf_prog_model.sv */
// Programmer model: programming mode levels and fuse, lock, erase strobes
module nlf_prog_model (
   input  wire logic       i_mclk,
   output logic            o_prog_mode,
   output logic            o_serial_mode,
   output logic            o_fuse_wr,
   output logic            o_fuse_sel_high,
   output logic [7:0]      o_fuse_wdata,
   output logic            o_lock_wr,
   output logic [7:0]      o_lock_wdata,
   output logic            o_chip_erase
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================================
   // Idle state at time zero
   initial begin
      {o_prog_mode, o_serial_mode, o_fuse_wr, o_fuse_sel_high, o_lock_wr, o_chip_erase} = '0;
      {o_fuse_wdata, o_lock_wdata} = '1;
   end
   // Mode change, then room for the two-flop synchroniser to settle
   task automatic mode(input logic p, input logic s);
      @(posedge i_mclk);
      o_prog_mode <= p;
      o_serial_mode <= s;
      repeat (3) @(posedge i_mclk);
   endtask
   // One-cycle strobe: 0 fuse write, 1 lock write, 2 chip erase
   task automatic op(input logic [1:0] k, input logic hi, input logic [7:0] d);
      @(posedge i_mclk);
      o_fuse_wr <= (k == 2'd0);
      o_lock_wr <= (k == 2'd1);
      o_chip_erase <= (k == 2'd2);
      o_fuse_sel_high <= hi;
      o_fuse_wdata <= d;
      o_lock_wdata <= d;
      @(posedge i_mclk);
      {o_fuse_wr, o_lock_wr, o_chip_erase} <= 3'b000;
      // Released data lines show no stale value
      o_fuse_wdata <= ~d;
      o_lock_wdata <= ~d;
   endtask
endmodule // nlf_prog_model

/* File: nlf_core_tb_top.sv */
// Testbench for nlf_core: defaults, latching, lock modes, signature, trim
module nlf_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================================
   // Signals named after the design ports
   logic        i_mclk, i_rstn, i_prog_mode, i_serial_mode, i_fuse_wr, i_fuse_sel_high;
   logic        i_lock_wr, i_chip_erase, i_sig_rd, i_sig_sel_cal, i_trim_wr;
   logic        i_pm_store, i_pm_load, i_vectors_in_boot;
   logic [1:0]  i_sig_addr, o_eeprom_byte_in_page;
   logic [7:0]  i_fuse_wdata, i_lock_wdata, i_trim_wdata, o_lock_byte, o_sig_rdata;
   logic [7:0]  o_config_fuse_high_byte, o_config_fuse_low_byte, o_oscillator_trim_register;
   logic [7:0]  o_active_fuse_high, o_active_fuse_low;
   logic [12:0] i_exec_pc, i_target_addr;
   logic [8:0]  i_ee_addr;
   logic        o_keep_eeprom, o_eeprom_erase, o_flash_erase, o_clocks_in_sleep;
   logic        o_store_allow, o_load_allow, o_irq_block;
   logic [6:0]  o_flash_page_select, o_eeprom_page;
   logic [5:0]  o_flash_word_in_page;
   int          n_errors, n_tests, n_fl, n_ee;
   logic [7:0]  sig_exp [3] = '{8'hA5, 8'h5A, 8'h3C}; // Arbitrary identity values set below
   logic [7:0]  cal_exp [4] = '{8'h81, 8'h82, 8'h84, 8'h88};
   logic [1:0]  modes [4] = '{2'b11, 2'b00, 2'b01, 2'b10}; // Upper, lower boot lock
   // Distinct trims so a wrong address shows
   nlf_core #(.SIG_BYTE0(8'hA5), .SIG_BYTE1(8'h5A), .SIG_BYTE2(8'h3C),
      .CAL_1MHZ(8'h81), .CAL_2MHZ(8'h82), .CAL_4MHZ(8'h84), .CAL_8MHZ(8'h88))
      i_dut (.*);
   nlf_prog_model i_pgm (.i_mclk, .o_prog_mode(i_prog_mode), .o_serial_mode(i_serial_mode),
      .o_fuse_wr(i_fuse_wr), .o_fuse_sel_high(i_fuse_sel_high), .o_fuse_wdata(i_fuse_wdata),
      .o_lock_wr(i_lock_wr), .o_lock_wdata(i_lock_wdata), .o_chip_erase(i_chip_erase));
   // ====================================
   // Clock, erase pulse counters, hang guard
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      n_fl += (i_rstn && o_flash_erase === 1'b1);
      n_ee += (i_rstn && o_eeprom_erase === 1'b1);
   end
   initial begin
      #1ms;
      n_errors++;
      complete_run();
   end
   // ====================================
   // Shared tasks
   task automatic chk(input string nm, input logic [12:0] got, input logic [12:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic sig(input logic c, input logic [1:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_sig_rd <= 1'b1;
      i_sig_sel_cal <= c;
      i_sig_addr <= a;
      @(posedge i_mclk);
      i_sig_rd <= 1'b0;
      #1 chk("sig_rdata", o_sig_rdata, e);
   endtask
   // Code at pc touches target t, vectors in boot when v; returns after the answer
   task automatic req(input logic [12:0] pc, input logic [12:0] t, input logic v = 1'b0);
      @(posedge i_mclk);
      {i_pm_store, i_pm_load, i_vectors_in_boot, i_exec_pc, i_target_addr} <= {2'b11, v, pc, t};
      @(posedge i_mclk);
      #1;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ====================================
   // Main sequence
   initial begin
      i_rstn = 1'b0;
      {i_sig_rd, i_sig_sel_cal, i_trim_wr, i_pm_store, i_pm_load, i_vectors_in_boot} = '0;
      {i_sig_addr, i_trim_wdata, i_exec_pc, i_target_addr, i_ee_addr} = '0;
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      #1 chk("fuse_high", o_config_fuse_high_byte, 8'h99);
      chk("fuse_low", o_config_fuse_low_byte, 8'hE1);
      chk("active_low", o_active_fuse_low, 8'hE1);
      chk("lock", o_lock_byte, 8'hFF);
      chk("trim", o_oscillator_trim_register, 8'h81);
      i_pgm.mode(1'b1, 1'b0);
      i_pgm.op(2'd2, 1'b0, 8'h00); // Erase while EEPROM not kept
      i_pgm.op(2'd0, 1'b1, 8'h11);
      #1 chk("fuse_high", o_config_fuse_high_byte, 8'h11);
      i_pgm.op(2'd0, 1'b0, 8'hE4);
      #1 chk("fuse_low", o_config_fuse_low_byte, 8'hE4);
      @(posedge i_mclk);
      #1 chk("keep_eeprom", o_keep_eeprom, 1'b1);
      chk("active_high", o_active_fuse_high, 8'h99);
      chk("active_low", o_active_fuse_low, 8'hE1);
      i_pgm.mode(1'b1, 1'b1);
      i_pgm.op(2'd0, 1'b1, 8'h30);
      #1 chk("fuse_high", o_config_fuse_high_byte, 8'h10);
      i_pgm.mode(1'b0, 1'b0);
      repeat (4) @(posedge i_mclk);
      #1 chk("active_high", o_active_fuse_high, 8'h10);
      chk("active_low", o_active_fuse_low, 8'hE4);
      chk("clk_sleep", o_clocks_in_sleep, 1'b1);
      i_pgm.mode(1'b1, 1'b0);
      foreach (modes[k]) begin
         i_pgm.op(2'd2, 1'b0, 8'h00);
         i_pgm.op(2'd1, 1'b0, {2'b11, modes[k], 4'hF});
         req(13'h0100, 13'h1FC0);
         chk("store_allow", o_store_allow, modes[k][0]);
         chk("load_allow", o_load_allow, modes[k][1]);
         req(13'h1FC0, 13'h1FC0);
         chk("irq_block", o_irq_block, !modes[k][1]);
         req(13'h1FC0, 13'h1FC0, 1'b1);
         chk("irq_block", o_irq_block, 1'b0);
      end
      req(13'h0100, 13'h1BFF);
      chk("store_allow", o_store_allow, 1'b1);
      req(13'h0100, 13'h1C00);
      chk("store_allow", o_store_allow, 1'b0);
      i_pgm.op(2'd1, 1'b0, 8'hFE);
      i_pgm.op(2'd0, 1'b1, 8'h00);
      #1 chk("fuse_high", o_config_fuse_high_byte, 8'h10);
      i_pgm.op(2'd1, 1'b0, 8'hFF);
      #1 chk("lock", o_lock_byte, 8'hEE);
      for (int a = 0; a < 4; a++) begin
         if (a < 3) begin
            sig(1'b0, 2'(a), sig_exp[a]);
         end
         sig(1'b1, 2'(a), cal_exp[a]);
      end
      i_pgm.op(2'd2, 1'b0, 8'h00);
      #1 chk("lock", o_lock_byte, 8'hFF);
      chk("fuse_high", o_config_fuse_high_byte, 8'h10);
      @(posedge i_mclk);
      i_ee_addr <= 9'h1A7;
      i_trim_wr <= 1'b1;
      i_trim_wdata <= 8'h3C;
      @(posedge i_mclk);
      i_trim_wr <= 1'b0;
      #1 chk("ee_page", o_eeprom_page, 7'h69);
      chk("ee_byte", o_eeprom_byte_in_page, 2'h3);
      chk("trim", o_oscillator_trim_register, 8'h3C);
      chk("flash_erases", n_fl, 6);
      chk("ee_erases", n_ee, 1);
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      @(posedge i_mclk);
      i_rstn <= 1'b1;
      #1 chk("trim", o_oscillator_trim_register, 8'h81);
      complete_run();
   end
endmodule // nlf_core_tb_top
